//--- hdl/dbg_comparator_control.sv
// Overview of operation
// - Comparators B and D: bit 6 zero matches word, one matches byte accesses.
// - Size ignored when size compare disabled or opcode tagging selected.
// - Comparators A and C use bit 6 as alternate data match instead.
// - Tag select zero: match triggers at once on the bus cycle.
// - Tag select one: match tags opcode; trigger only when it executes.
// - Halt select zero: breakpoint only once sequencer reaches final state.
// - Halt select one: match breaks at once, stops tracing, disarms.
// - No breakpoint unless halt request enable bits are set.
// - Direction value zero matches writes, one matches reads.
// - Direction mismatch gives no match; agreement compares write or read data.
// - Direction compare enable bit includes read/write signal in comparison.
// - Direction compare disabled: direction value ignored, any direction matches.
// - Tagged triggering ignores direction enable and direction value.
// - Bus select zero watches core buses, one watches coprocessor buses.
// - Comparator on zero keeps it inactive; one feeds triggers or tags.
// - Arming puts sequencer into state one, flags read one.
// - Internal trigger ending a session returns sequencer to state zero.
`timescale 1ns/10ps
`include "dbg_cmp_cfg.svh"

module dbg_comparator_control #(
    parameter int N_CMP = 4
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input dbg_cmp_pkg::bus_cycle_t i_core_bus,
    input dbg_cmp_pkg::bus_cycle_t i_copr_bus,
    input wire logic [3:0] i_exec_tags,
    output logic [3:0] o_tag,
    output logic o_halt_core,
    output logic o_halt_copr,
    output logic o_trace_stop,
    output logic o_armed,
    output logic o_irq
);

    initial begin
        if (N_CMP != 4) begin
            $error("N_CMP must be 4: the register map holds four comparators");
        end
    end

    dbg_cmp_pkg::ctl_t ctl_r [4];
    logic [`BUS_AW-1:0] addr_r [4];
    logic [`BUS_DW-1:0] data_r [4];
    logic arm_r;
    logic [1:0] halt_en_r;
    dbg_cmp_pkg::seq_state_t state_r, state_nxt;
    logic [`IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r;
    logic [31:0] prdata_r, rd_mux;
    logic pready_r, pslverr_r;
    logic [3:0] tag_r;
    logic halt_core_r, halt_copr_r, trace_stop_r, irq_r;

    logic acc, first_acc, wr_en, rd_en, mapped;
    logic [3:0] idx;
    logic dbgc_wr, arm_set, imm, adv, session_end;
    logic [3:0] trig, tagm, brk_sel;

    // Word indices of the fixed registers, taken from their byte offsets
    localparam logic [3:0] IX_DBG_CTL = 4'(`OFF_DBG_CTL >> 2);
    localparam logic [3:0] IX_IRQ_STAT = 4'(`OFF_IRQ_STAT >> 2);
    localparam logic [3:0] IX_IRQ_MASK = 4'(`OFF_IRQ_MASK >> 2);

    // APB: one wait state so every answer leaves from a flip-flop
    assign acc = i_psel && i_penable;
    assign first_acc = acc && !pready_r;
    assign wr_en = acc && pready_r && i_pwrite;
    assign rd_en = acc && pready_r && !i_pwrite;
    assign mapped = (i_paddr[7:6] == 2'b00);
    assign idx = i_paddr[5:2];

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx[3:2])
            2'd0: rd_mux = {24'h00_0000, ctl_r[idx[1:0]]};
            2'd1: rd_mux = {16'h0000, addr_r[idx[1:0]]};
            2'd2: rd_mux = {16'h0000, data_r[idx[1:0]]};
            2'd3: begin
                unique case (idx[1:0])
                    2'd0: rd_mux = {29'h0000_0000, halt_en_r, arm_r};
                    2'd1: rd_mux = {29'h0000_0000, state_r};
                    2'd2: rd_mux = {29'h0000_0000, irq_stat_r};
                    2'd3: rd_mux = {29'h0000_0000, irq_mask_r};
                endcase
            end
        endcase
        if (!mapped) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= first_acc;
            pslverr_r <= first_acc && !mapped;
            if (first_acc) begin
                prdata_r <= i_pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Comparator registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int k = 0; k < 4; k++) begin
                ctl_r[k] <= `CTL_RESET;
                addr_r[k] <= `WORD_RESET;
                data_r[k] <= `WORD_RESET;
            end
        end else if (wr_en && mapped) begin
            unique case (idx[3:2])
                2'd0: begin
                    if (i_pstrb[0]) begin
                        ctl_r[idx[1:0]] <= i_pwdata[7:0];
                    end
                end
                2'd1: begin
                    if (i_pstrb[0]) begin
                        addr_r[idx[1:0]][7:0] <= i_pwdata[7:0];
                    end
                    if (i_pstrb[1]) begin
                        addr_r[idx[1:0]][15:8] <= i_pwdata[15:8];
                    end
                end
                2'd2: begin
                    if (i_pstrb[0]) begin
                        data_r[idx[1:0]][7:0] <= i_pwdata[7:0];
                    end
                    if (i_pstrb[1]) begin
                        data_r[idx[1:0]][15:8] <= i_pwdata[15:8];
                    end
                end
                2'd3: begin
                end
            endcase
        end
    end

    // Comparator channels; odd indices (B, D) carry the size check
    for (genvar g = 0; g < 4; g++) begin : g_cmp
        cmp_channel #(
            .HAS_SIZE(g % 2)
        ) u_cmp (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_ctl(ctl_r[g]),
            .i_addr(addr_r[g]),
            .i_data(data_r[g]),
            .i_core(i_core_bus),
            .i_copr(i_copr_bus),
            .i_armed(arm_r),
            .i_exec_tag(i_exec_tags[g]),
            .o_trig(trig[g]),
            .o_tag(tagm[g])
        );
        assign brk_sel[g] = ctl_r[g].immediate_halt_select;
    end

    assign dbgc_wr = wr_en && mapped && (idx == IX_DBG_CTL) && i_pstrb[0];
    assign arm_set = dbgc_wr && i_pwdata[`DBGC_ARM_BIT];
    // Any channel with its halt bit ends the session at once, whatever the state
    assign imm = arm_r && |(trig & brk_sel);
    assign adv = arm_r && |trig;
    // Final state is held one cycle so software can see it, then the session ends
    assign session_end = arm_r && (imm || (state_r == dbg_cmp_pkg::SEQ_FINAL));

    // Software write of the arm bit wins over an internal disarm in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            arm_r <= 1'b0;
            halt_en_r <= 2'b00;
        end else if (dbgc_wr) begin
            arm_r <= i_pwdata[`DBGC_ARM_BIT];
            halt_en_r <= {i_pwdata[`DBGC_HALT_CORE_BIT], i_pwdata[`DBGC_HALT_COPR_BIT]};
        end else if (session_end) begin
            arm_r <= 1'b0;
        end
    end

    // Software disarm leaves the state as it was, showing the last state reached
    always_comb begin
        state_nxt = state_r;
        if (arm_set) begin
            state_nxt = dbg_cmp_pkg::SEQ_ONE;
        end else if (session_end) begin
            state_nxt = dbg_cmp_pkg::SEQ_IDLE;
        end else if (adv) begin
            unique case (state_r)
                dbg_cmp_pkg::SEQ_IDLE: state_nxt = dbg_cmp_pkg::SEQ_IDLE;
                dbg_cmp_pkg::SEQ_ONE: state_nxt = dbg_cmp_pkg::SEQ_TWO;
                dbg_cmp_pkg::SEQ_TWO: state_nxt = dbg_cmp_pkg::SEQ_THREE;
                dbg_cmp_pkg::SEQ_THREE: state_nxt = dbg_cmp_pkg::SEQ_FINAL;
                dbg_cmp_pkg::SEQ_FINAL: state_nxt = dbg_cmp_pkg::SEQ_FINAL;
                default: state_nxt = dbg_cmp_pkg::SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= dbg_cmp_pkg::SEQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Halt outputs are one-cycle pulses
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            halt_core_r <= 1'b0;
            halt_copr_r <= 1'b0;
            trace_stop_r <= 1'b0;
            tag_r <= 4'h0;
        end else begin
            halt_core_r <= session_end && halt_en_r[1];
            halt_copr_r <= session_end && halt_en_r[0];
            trace_stop_r <= session_end;
            tag_r <= tagm;
        end
    end

    // Sticky events; an event in the clearing read's cycle survives
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (rd_en && mapped && (idx == IX_IRQ_STAT)) begin
            irq_stat_nxt = `IRQ_RESET;
        end
        irq_stat_nxt[`IRQ_BRK_BIT] = irq_stat_nxt[`IRQ_BRK_BIT] || (session_end && |halt_en_r);
        irq_stat_nxt[`IRQ_END_BIT] = irq_stat_nxt[`IRQ_END_BIT] || session_end;
        irq_stat_nxt[`IRQ_TRIG_BIT] = irq_stat_nxt[`IRQ_TRIG_BIT] || adv;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_stat_r <= `IRQ_RESET;
            irq_mask_r <= `IRQ_RESET;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_en && mapped && (idx == IX_IRQ_MASK) && i_pstrb[0]) begin
                irq_mask_r <= i_pwdata[`IRQ_W-1:0];
            end
            irq_r <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_tag = tag_r;
    assign o_halt_core = halt_core_r;
    assign o_halt_copr = halt_copr_r;
    assign o_trace_stop = trace_stop_r;
    assign o_armed = arm_r;
    assign o_irq = irq_r;

    a_arm_state_one: assert property (@(posedge i_clk) disable iff (!i_rstn)
        arm_set |=> (state_r == dbg_cmp_pkg::SEQ_ONE) && arm_r)
        else $error("arming did not enter state one");

    a_end_state_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (session_end && !dbgc_wr) |=> (state_r == dbg_cmp_pkg::SEQ_IDLE) && !arm_r)
        else $error("internal end did not return to state zero");

    a_final_only_brk: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_trace_stop) |-> $past(state_r) == dbg_cmp_pkg::SEQ_FINAL || $past(imm))
        else $error("breakpoint outside final state without immediate halt");

    a_imm_halt_now: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (imm && halt_en_r[1]) |=> o_halt_core && o_trace_stop ##1 !o_halt_core)
        else $error("immediate halt not raised for one cycle");

    a_brk_needs_en: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (o_halt_core || o_halt_copr) |-> $past(halt_en_r) != 2'b00)
        else $error("breakpoint with halt requests disabled");

    a_ctl_reset_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !$past(i_rstn) |-> ctl_r[0] == 8'h00 && ctl_r[3] == 8'h00)
        else $error("control bits not zero after reset");

    a_tag_to_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
        tagm[0] |=> o_tag[0])
        else $error("opcode tag not presented");

    // A write of the arm bit restarts the sequencer, so that cycle is left out here
    a_final_ends: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (arm_r && state_r == dbg_cmp_pkg::SEQ_FINAL && !dbgc_wr) |=> o_trace_stop && !arm_r)
        else $error("final state did not end the session");

    a_copr_needs_en: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_halt_copr |-> $past(halt_en_r[0]))
        else $error("coprocessor breakpoint with its request disabled");

    a_unarmed_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !arm_r |-> trig == 4'h0 && tagm == 4'h0)
        else $error("comparator active while disarmed");

    a_tag_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_tag[1] |-> $past(tagm[1]))
        else $error("opcode tag without a tagged match");

    // Every answer is a single-cycle ready
    a_pready_pulse: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_pready |=> !o_pready)
        else $error("ready held past one cycle");

    a_err_with_ready: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_pslverr |-> o_pready)
        else $error("error response outside the end of a transfer");

    // Main scenarios worth reaching
    c_arm_to_halt: cover property (@(posedge i_clk) disable iff (!i_rstn)
        arm_set ##[1:200] o_halt_core);

    c_tagged_trig: cover property (@(posedge i_clk) disable iff (!i_rstn)
        o_tag[1] ##[1:50] trig[1]);

    c_unmapped: cover property (@(posedge i_clk) disable iff (!i_rstn) o_pslverr);

    c_irq: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_irq));

    c_final_state: cover property (@(posedge i_clk) disable iff (!i_rstn)
        state_r == dbg_cmp_pkg::SEQ_FINAL);

endmodule // dbg_comparator_control

//--- common/dbg_cmp_cfg.svh
`ifndef DBG_CMP_CFG_SVH
`define DBG_CMP_CFG_SVH

// Observed bus widths
`define BUS_AW 16
`define BUS_DW 16

// Register byte offsets; four comparators sit at base + 4 * index
`define OFF_CTL_BASE 8'h00
`define OFF_ADDR_BASE 8'h10
`define OFF_DATA_BASE 8'h20
`define OFF_DBG_CTL 8'h30
`define OFF_SEQ_STAT 8'h34
`define OFF_IRQ_STAT 8'h38
`define OFF_IRQ_MASK 8'h3c

// Reset values
`define CTL_RESET 8'h00
`define WORD_RESET 16'h0000
`define IRQ_RESET 3'h0

// Debug control fields
`define DBGC_ARM_BIT 0
`define DBGC_HALT_COPR_BIT 1
`define DBGC_HALT_CORE_BIT 2

// Interrupt status fields
`define IRQ_W 3
`define IRQ_BRK_BIT 0
`define IRQ_END_BIT 1
`define IRQ_TRIG_BIT 2

`endif

//--- common/dbg_cmp_pkg.sv
`include "dbg_cmp_cfg.svh"

package dbg_cmp_pkg;

    // One observed bus cycle
    typedef struct packed {
        logic valid;
        logic rnw;
        logic byte_sz;
        logic [`BUS_AW-1:0] addr;
        logic [`BUS_DW-1:0] wdata;
        logic [`BUS_DW-1:0] rdata;
    } bus_cycle_t;

    // Comparator control register, bit 7 down to bit 0
    typedef struct packed {
        logic size_compare_enable;
        logic access_size_select;
        logic opcode_tag_select;
        logic immediate_halt_select;
        logic direction_value;
        logic direction_compare_enable;
        logic bus_master_select;
        logic comparator_on;
    } ctl_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_ONE = 3'b001,
        SEQ_TWO = 3'b010,
        SEQ_THREE = 3'b011,
        SEQ_FINAL = 3'b100
    } seq_state_t;

endpackage

//--- hdl/cmp_channel.sv
`timescale 1ns/10ps
`include "dbg_cmp_cfg.svh"

module cmp_channel #(
    parameter int HAS_SIZE = 1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input dbg_cmp_pkg::ctl_t i_ctl,
    input wire logic [`BUS_AW-1:0] i_addr,
    input wire logic [`BUS_DW-1:0] i_data,
    input dbg_cmp_pkg::bus_cycle_t i_core,
    input dbg_cmp_pkg::bus_cycle_t i_copr,
    input wire logic i_armed,
    input wire logic i_exec_tag,
    output logic o_trig,
    output logic o_tag
);

    initial begin
        if (HAS_SIZE != 0 && HAS_SIZE != 1) begin
            $error("HAS_SIZE must be 0 or 1");
        end
    end

    dbg_cmp_pkg::bus_cycle_t bus;
    logic [`BUS_DW-1:0] bus_data;
    logic addr_hit, dir_ok, size_ok, data_ok, hit, active;

    assign bus = i_ctl.bus_master_select ? i_copr : i_core;
    assign bus_data = bus.rnw ? bus.rdata : bus.wdata;
    assign addr_hit = bus.valid && (bus.addr == i_addr);
    // Direction is a don't-care when disabled or when tagging
    assign dir_ok = i_ctl.opcode_tag_select || !i_ctl.direction_compare_enable
        || (i_ctl.direction_value == bus.rnw);
    // Size select: 0 word, 1 byte; data-match comparators have no size check
    assign size_ok = (HAS_SIZE == 0) || i_ctl.opcode_tag_select
        || !i_ctl.size_compare_enable || (i_ctl.access_size_select == bus.byte_sz);
    // On data-match comparators bit 6 inverts the data match
    assign data_ok = (HAS_SIZE != 0) || !i_ctl.size_compare_enable
        || ((bus_data == i_data) ^ i_ctl.access_size_select);
    assign active = i_armed && i_ctl.comparator_on;
    assign hit = active && addr_hit && dir_ok && size_ok && data_ok;
    assign o_trig = i_ctl.opcode_tag_select ? (active && i_exec_tag) : hit;
    assign o_tag = hit && i_ctl.opcode_tag_select;

    a_dir_mismatch: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!i_ctl.opcode_tag_select && i_ctl.direction_compare_enable
        && (i_ctl.direction_value != bus.rnw)) |-> !o_trig)
        else $error("match despite direction mismatch");
    a_tag_waits_exec: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (i_ctl.opcode_tag_select && !i_exec_tag) |-> !o_trig)
        else $error("tagged trigger without execution");
    a_off_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !i_ctl.comparator_on |-> !o_trig && !o_tag)
        else $error("disabled comparator fired");
    a_size_mismatch: assert property (@(posedge i_clk) disable iff (!i_rstn)
        ((HAS_SIZE == 1) && i_ctl.size_compare_enable && !i_ctl.opcode_tag_select
        && (i_ctl.access_size_select != bus.byte_sz)) |-> !o_trig)
        else $error("match despite size mismatch");
    a_src_core_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!i_ctl.bus_master_select && !i_core.valid && !i_ctl.opcode_tag_select)
        |-> !o_trig)
        else $error("core comparator fired with idle core bus");
    a_dir_dontcare: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (active && !i_ctl.opcode_tag_select && !i_ctl.direction_compare_enable
        && addr_hit && size_ok && data_ok) |-> o_trig)
        else $error("direction blocked match while ignored");

endmodule // cmp_channel

//--- testbench/bus_partner.sv
`timescale 1ns/10ps
`include "dbg_cmp_cfg.svh"

module bus_partner (
    input wire logic i_clk,
    input wire logic i_rstn,
    input dbg_cmp_pkg::bus_cycle_t i_req,
    input wire logic i_req_copr,
    input wire logic [3:0] i_tag,
    input wire logic i_exec_en,
    input wire logic [2:0] i_exec_dly,
    output dbg_cmp_pkg::bus_cycle_t o_core,
    output dbg_cmp_pkg::bus_cycle_t o_copr,
    output logic [3:0] o_exec_tags
);
    logic [3:0] pend_r;
    logic [2:0] cnt_r;

    // Idle buses toggle every field except valid, which is held low, so a stale value never passes for a cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core <= '0;
            o_copr <= '0;
        end else begin
            o_core <= ~o_core;
            o_copr <= ~o_copr;
            o_core.valid <= 1'b0;
            o_copr.valid <= 1'b0;
            if (i_req.valid && i_req_copr) begin
                o_copr <= i_req;
            end else if (i_req.valid) begin
                o_core <= i_req;
            end
        end
    end

    // A marked opcode reaches execution after a queue delay, or is flushed
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_r <= 4'h0;
            cnt_r <= 3'h0;
            o_exec_tags <= 4'h0;
        end else begin
            o_exec_tags <= (cnt_r == 3'h1) ? pend_r : 4'h0;
            if (|i_tag && i_exec_en) begin
                pend_r <= i_tag;
                cnt_r <= i_exec_dly;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end
endmodule // bus_partner

//--- testbench/dbg_comparator_control_tb.sv
`timescale 1ns/10ps
`include "dbg_cmp_cfg.svh"

module dbg_comparator_control_tb;
    localparam logic [15:0] ADR = 16'h1230;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, req_copr, ex_en;
    logic irq, armed, h_core, h_copr, t_stop;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] ex_dly;
    logic [3:0] tag, exec;
    dbg_cmp_pkg::bus_cycle_t req, core, copr;
    logic [64:0] e;
    logic [64:0] exp_q[$];
    int fails, cmp_count, halt_cnt, trace_cnt, copr_cnt, tag_cnt, h, s, c;

    dbg_comparator_control uut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'hf), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_core_bus(core), .i_copr_bus(copr), .i_exec_tags(exec), .o_tag(tag),
        .o_halt_core(h_core), .o_halt_copr(h_copr), .o_trace_stop(t_stop),
        .o_armed(armed), .o_irq(irq));

    bus_partner far (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_req_copr(req_copr),
        .i_tag(tag), .i_exec_en(ex_en), .i_exec_dly(ex_dly), .o_core(core),
        .o_copr(copr), .o_exec_tags(exec));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] ev, input logic [31:0] got);
        cmp_count++;
        if (got !== ev) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, ev, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Result watcher: each completed transfer takes the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            if (exp_q.size() == 0) begin
                chk("unexpected transfer", 32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                chk("pslverr", 32'(e[64]), 32'(pslverr));
                chk("prdata", e[31:0], prdata & e[63:32]);
            end
        end
        if (h_core || h_copr) halt_cnt++;
        if (t_stop) trace_cnt++;
        if (h_copr) copr_cnt++;
        if (|tag) tag_cnt++;
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic [32:0] ev);
        int n;
        exp_q.push_back({ev[32], m, ev[31:0]});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready timeout", 32'h1, 32'h0);
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [32:0] ev);
        apb(1'b0, a, 32'h0, m, ev);
    endtask

    // One observed bus cycle at the compare address, other data lane random
    task automatic cyc(input logic cp, input logic rnw, input logic byt, input logic [15:0] d);
        logic [15:0] r;
        r = 16'($urandom);
        @(posedge clk);
        req <= '{valid: 1'b1, rnw: rnw, byte_sz: byt, addr: ADR,
                 wdata: rnw ? r : d, rdata: rnw ? d : r};
        req_copr <= cp;
        @(posedge clk);
        req.valid <= 1'b0;
        repeat (14) @(posedge clk);
    endtask

    task automatic trial(input logic [1:0] ix, input logic [7:0] ctl, input logic cp,
                         input logic rnw, input logic byt, input logic [15:0] d,
                         input logic ex, input logic t);
        chk("irq idle", 32'h0, 32'(irq));
        ex_en <= ex;
        ex_dly <= 3'($urandom_range(5, 1));
        wr({4'h0, ix, 2'b00}, {24'h0, ctl});
        wr(8'h30, 32'h1);
        cyc(cp, rnw, byt, d);
        chk("irq", 32'(t), 32'(irq));
        rd(8'h38, 32'h4, {30'h0, t, 2'b00});
        wr({4'h0, ix, 2'b00}, 32'h0);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        req = '0;
        req_copr = 1'b0;
        ex_en = 1'b0;
        ex_dly = 3'h1;
        fails = 0;
        cmp_count = 0;
        halt_cnt = 0;
        trace_cnt = 0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        void'($urandom(32'hc0451bf5));
        for (int a = 0; a < 64; a += 4) rd(8'(a), 32'hffffffff, 33'h0);
        rd(8'h40, 32'hffffffff, {1'b1, 32'h0});
        apb(1'b1, 8'h80, 32'h1, 32'h0, {1'b1, 32'h0});
        wr(8'h34, 32'h7);
        rd(8'h34, 32'hffffffff, 33'h0);
        wr(8'h0c, 32'ha5);
        rd(8'h0c, 32'hffffffff, 33'ha5);
        wr(8'h0c, 32'h0);
        $display("test register map done");
        for (int i = 0; i < 4; i++) wr(8'(8'h10 + 4 * i), {16'h0, ADR});
        wr(8'h20, 32'haa);
        wr(8'h28, 32'haa);
        wr(8'h3c, 32'h4);
        trial(0, 8'h00, 0, 0, 0, 16'haa, 0, 0);
        trial(0, 8'h01, 0, 0, 0, 16'haa, 0, 1);
        trial(0, 8'h01, 1, 0, 0, 16'haa, 0, 0);
        trial(0, 8'h03, 1, 0, 0, 16'haa, 0, 1);
        trial(0, 8'h03, 0, 0, 0, 16'haa, 0, 0);
        trial(0, 8'h05, 0, 0, 0, 16'haa, 0, 1);
        trial(0, 8'h05, 0, 1, 0, 16'haa, 0, 0);
        trial(0, 8'h0d, 0, 0, 0, 16'haa, 0, 0);
        trial(0, 8'h0d, 0, 1, 0, 16'haa, 0, 1);
        trial(0, 8'h09, 0, 0, 0, 16'haa, 0, 1);
        trial(0, 8'h01, 0, 1, 0, 16'haa, 0, 1);
        trial(1, 8'h81, 0, 0, 0, 16'haa, 0, 1);
        trial(1, 8'h81, 0, 0, 1, 16'haa, 0, 0);
        trial(1, 8'hc1, 0, 1, 1, 16'haa, 0, 1);
        trial(3, 8'hc1, 0, 0, 0, 16'haa, 0, 0);
        trial(1, 8'h41, 0, 0, 0, 16'haa, 0, 1);
        trial(1, 8'he1, 0, 0, 0, 16'haa, 1, 1);
        trial(0, 8'h21, 0, 0, 0, 16'haa, 0, 0);
        trial(0, 8'h21, 0, 1, 0, 16'haa, 1, 1);
        trial(0, 8'h2d, 0, 0, 0, 16'haa, 1, 1);
        trial(0, 8'h85, 0, 0, 0, 16'haa, 0, 1);
        trial(0, 8'h81, 0, 1, 0, 16'h55, 0, 0);
        trial(0, 8'hc1, 0, 0, 0, 16'h55, 0, 1);
        trial(2, 8'hc1, 0, 1, 0, 16'haa, 0, 0);
        chk("tag pulses", 32'h4, 32'(tag_cnt));
        $display("test match conditions done");
        wr(8'h00, 32'h11);
        wr(8'h30, 32'h7);
        rd(8'h34, 32'h7, 33'h1);
        chk("armed", 32'h1, 32'(armed));
        h = halt_cnt;
        s = trace_cnt;
        c = copr_cnt;
        cyc(0, 0, 0, 16'h0);
        chk("halt count", 32'(h + 1), 32'(halt_cnt));
        chk("trace stop count", 32'(s + 1), 32'(trace_cnt));
        chk("armed", 32'h0, 32'(armed));
        rd(8'h34, 32'h7, 33'h0);
        rd(8'h38, 32'h3, 33'h3);
        wr(8'h30, 32'h1);
        cyc(0, 0, 0, 16'h0);
        chk("halt count", 32'(h + 1), 32'(halt_cnt));
        chk("trace stop count", 32'(s + 2), 32'(trace_cnt));
        rd(8'h38, 32'h0, 33'h0);
        $display("test immediate halt done");
        wr(8'h00, 32'h01);
        wr(8'h30, 32'h5);
        cyc(0, 0, 0, 16'h0);
        cyc(0, 1, 0, 16'h0);
        chk("halt count", 32'(h + 1), 32'(halt_cnt));
        rd(8'h34, 32'h7, 33'h3);
        cyc(0, 0, 1, 16'h0);
        chk("halt count", 32'(h + 2), 32'(halt_cnt));
        chk("coprocessor halt count", 32'(c + 1), 32'(copr_cnt));
        chk("armed", 32'h0, 32'(armed));
        rd(8'h34, 32'h7, 33'h0);
        rd(8'h38, 32'h0, 33'h0);
        $display("test final state done");
        wr(8'h3c, 32'h0);
        wr(8'h30, 32'h1);
        cyc(0, 0, 0, 16'h0);
        chk("irq masked", 32'h0, 32'(irq));
        wr(8'h3c, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, 32'(irq));
        rd(8'h38, 32'h4, 33'h4);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        $display("test interrupt done");
        give_verdict();
    end
endmodule // dbg_comparator_control_tb
